// [core/tlptx_pkg.sv]
package tlptx_pkg;
  // Build-time choices
  localparam int TLPTX_DATA_W = 64;
  localparam int TLPTX_NUM_BUFS = 8;
  localparam int TLPTX_MAX_PKT_BYTES = 272;
  localparam int TLPTX_CNT_W = 6;
  localparam int TLPTX_USER_W = 4;

  // Side-band bit positions
  localparam int TLPTX_U_ECRC = 0;
  localparam int TLPTX_U_POISON = 1;
  localparam int TLPTX_U_STREAM = 2;
  localparam int TLPTX_U_DISCONT = 3;

  // Timing
  localparam int TLPTX_CLK_NS = 10;
  localparam int TLPTX_DRAIN_NS = 200;
  localparam int TLPTX_DRAIN_CYC = TLPTX_DRAIN_NS / TLPTX_CLK_NS;

  // Register offsets
  localparam logic [7:0] TLPTX_OFS_CTRL = 8'h00;
  localparam logic [7:0] TLPTX_OFS_LEN = 8'h04;
  localparam logic [7:0] TLPTX_OFS_SEED = 8'h08;
  localparam logic [7:0] TLPTX_OFS_ABORT = 8'h0c;
  localparam logic [7:0] TLPTX_OFS_GO = 8'h10;
  localparam logic [7:0] TLPTX_OFS_STATUS = 8'h14;
  localparam logic [7:0] TLPTX_OFS_INT_STAT = 8'h18;
  localparam logic [7:0] TLPTX_OFS_INT_CLR = 8'h1c;
  localparam logic [7:0] TLPTX_OFS_INT_EN = 8'h20;

  // Control fields
  localparam int TLPTX_CTRL_STREAM = 0;
  localparam int TLPTX_CTRL_POISON = 1;
  localparam int TLPTX_CTRL_ECRC = 2;
  localparam int TLPTX_CTRL_GNT_PULSE = 3;
  localparam int TLPTX_CTRL_ABORT = 4;
  localparam int TLPTX_CTRL_W = 5;
  localparam int TLPTX_LEN_W = 10;
  localparam int TLPTX_BEAT_W = 8;

  // Status and interrupt fields
  localparam int TLPTX_ST_BUSY = 0;
  localparam int TLPTX_ST_REQ = 1;
  localparam int TLPTX_ST_FREE = 8;
  localparam int TLPTX_INT_SENT = 0;
  localparam int TLPTX_INT_DROP = 1;
  localparam int TLPTX_INT_REQ = 2;
  localparam int TLPTX_INT_W = 3;

  typedef enum logic {TLPTX_IDLE, TLPTX_SEND} tlptx_gen_t;
endpackage

// [core/tlptx_if.sv]
`timescale 1ns/1ps
interface tlptx_if
  import tlptx_pkg::*;
#(
  parameter int DATA_W = TLPTX_DATA_W
);
  logic [DATA_W-1:0] tdata;
  logic [DATA_W/8-1:0] tkeep;
  logic tvalid;
  logic tready;
  logic tlast;
  logic [TLPTX_USER_W-1:0] tuser;
  logic [TLPTX_CNT_W-1:0] free_buffer_count;
  logic err_drop;
  logic cfg_req;
  logic cfg_gnt;

  modport core (
    input tdata, tkeep, tvalid, tlast, tuser, cfg_gnt,
    output tready, free_buffer_count, err_drop, cfg_req
  );
  modport user (
    output tdata, tkeep, tvalid, tlast, tuser, cfg_gnt,
    input tready, free_buffer_count, err_drop, cfg_req
  );
endinterface

// [core/tlptx_core_end.sv]
`timescale 1ns/1ps
module tlptx_core_end
  import tlptx_pkg::*;
#(
  parameter int DATA_W = TLPTX_DATA_W,
  parameter int NUM_BUFS = TLPTX_NUM_BUFS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link to the user side
  tlptx_if.core lnk,
  // Internal packet source and sent pulses
  input wire logic internal_post,
  output logic internal_sent,
  output logic link_sent
);
  localparam int KB = DATA_W / 8;
  localparam int DPB = DATA_W / 32;
  localparam int MAX_BEATS = (TLPTX_MAX_PKT_BYTES + KB - 1) / KB;
  localparam logic [7:0] MAX_BEAT_IDX = 8'(MAX_BEATS - 1);
  localparam logic [7:0] DRAIN_LAST = 8'(TLPTX_DRAIN_CYC - 1);

  if (DATA_W != 64 && DATA_W != 128) begin : g_bad_w
    $error("DATA_W must be 64 or 128");
  end
  if (NUM_BUFS < 1 || NUM_BUFS > 63 || MAX_BEATS > 255) begin : g_bad_n
    $error("NUM_BUFS must be 1..63");
  end

  logic in_pkt, cur_str, bad, gnt_cap, req, ready, drop;
  logic [7:0] beat_cnt, drain_cnt;
  logic [TLPTX_CNT_W-1:0] free_cnt, filled;
  logic last_ok;

  wire beat = lnk.tvalid & ready;
  wire sof = beat & !in_pkt;
  wire eof = beat & lnk.tlast;
  wire keep_full = &lnk.tkeep;
  wire dsc = lnk.tuser[TLPTX_U_DISCONT];
  wire str_now = sof ? lnk.tuser[TLPTX_U_STREAM] : cur_str;
  // A gap inside a cut-through packet cannot be repaired later
  wire gap_bad = in_pkt & cur_str & !lnk.tvalid;
  wire too_long = beat_cnt == MAX_BEAT_IDX && !lnk.tlast;
  wire len_bad = beat & ((lnk.tlast ? !last_ok : !keep_full) | too_long);
  wire bad_now = len_bad | gap_bad;
  wire int_take = !in_pkt & req & (free_cnt != '0) & !beat &
                  (gnt_cap | !lnk.tvalid);
  wire drain_hit = (drain_cnt == DRAIN_LAST) & (filled != '0);
  wire give = eof & (bad | bad_now | dsc);
  wire keep_pkt = eof & !(bad | bad_now | dsc);
  wire next_in_pkt = sof ? !lnk.tlast : (eof ? 1'b0 : in_pkt);
  // A drain and a failed packet end may fall together: count both returns
  wire [TLPTX_CNT_W-1:0] next_free = free_cnt - TLPTX_CNT_W'(sof | int_take)
                                     + TLPTX_CNT_W'(drain_hit)
                                     + TLPTX_CNT_W'(give);
  wire [TLPTX_CNT_W-1:0] next_filled = filled
                                       + TLPTX_CNT_W'(keep_pkt | int_take)
                                       - TLPTX_CNT_W'(drain_hit);
  wire next_req = int_take ? 1'b0 : (req | internal_post);
  wire next_gnt = int_take ? 1'b0 : (gnt_cap | (req & lnk.cfg_gnt));
  // Holding off new packets lets a granted internal packet go first
  wire next_ready = next_in_pkt |
                    ((next_free != '0) & !(next_req & next_gnt));

  // Final-beat keep must be a low run of whole dwords
  always_comb begin
    last_ok = lnk.tkeep[3:0] == 4'hf;
    for (int i = 1; i < DPB; i++) begin
      if (lnk.tkeep[4*i +: 4] != 4'h0 && lnk.tkeep[4*i +: 4] != 4'hf) begin
        last_ok = 1'b0;
      end
      if (lnk.tkeep[4*i +: 4] == 4'hf && lnk.tkeep[4*i-4 +: 4] != 4'hf) begin
        last_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_pkt <= 1'b0;
      cur_str <= 1'b0;
      bad <= 1'b0;
      beat_cnt <= 8'h00;
    end else begin
      in_pkt <= next_in_pkt;
      cur_str <= str_now;
      bad <= next_in_pkt & (bad | bad_now);
      beat_cnt <= next_in_pkt ? (sof ? 8'h01 : beat_cnt + 8'(beat)) : 8'h00;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      free_cnt <= TLPTX_CNT_W'(NUM_BUFS);
      filled <= '0;
      drain_cnt <= 8'h00;
      req <= 1'b0;
      gnt_cap <= 1'b0;
      ready <= 1'b0;
    end else begin
      free_cnt <= next_free;
      filled <= next_filled;
      drain_cnt <= (drain_cnt == DRAIN_LAST) ? 8'h00 : drain_cnt + 8'h01;
      req <= next_req;
      gnt_cap <= next_gnt;
      ready <= next_ready;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      drop <= 1'b0;
      internal_sent <= 1'b0;
      link_sent <= 1'b0;
    end else begin
      drop <= (bad_now & !bad) & (in_pkt | sof);
      internal_sent <= int_take;
      link_sent <= drain_hit;
    end
  end

  assign lnk.tready = ready;
  assign lnk.free_buffer_count = free_cnt;
  assign lnk.err_drop = drop;
  assign lnk.cfg_req = req;
endmodule

// [core/tlptx_user_end.sv]
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Data bus is 64 or 128 bits, fixed.
// - Beat moves only when valid and ready.
// - Keep bit n qualifies data byte n.
// - Non-final beats carry all keep bits set.
// - 64-bit final keep is 0x0f or 0xff.
// - 128-bit final keep is low 4/8/12/16 bytes.
// - Core ready high when it accepts beats.
// - Discontinue never on the start beat.
// - Discontinue always comes with last beat.
// - Core reports six-bit free buffer count.
// - One free buffer holds one packet.
// - Core flags dropped packets with error pulse.
// - Streamed packets go on consecutive cycles.
// - Core requests to send its own packets.
// - Grant pulse prioritises, held grant keeps default.
// - Poison any beat, never on streamed packets.
// - ECRC request on the first beat.
module tlptx_user_end
  import tlptx_pkg::*;
#(
  parameter int DATA_W = TLPTX_DATA_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Link to the core
  tlptx_if.user lnk
);
  localparam int DPB = DATA_W / 32;
  localparam int KB = DATA_W / 8;
  localparam logic [TLPTX_LEN_W-1:0] DPB_L = TLPTX_LEN_W'(DPB);

  if (DATA_W != 64 && DATA_W != 128) begin : g_bad_w
    $error("DATA_W must be 64 or 128");
  end

  // Register decode
  wire sel_ctrl = paddr == TLPTX_OFS_CTRL;
  wire sel_len = paddr == TLPTX_OFS_LEN;
  wire sel_seed = paddr == TLPTX_OFS_SEED;
  wire sel_abort = paddr == TLPTX_OFS_ABORT;
  wire sel_go = paddr == TLPTX_OFS_GO;
  wire sel_stat = paddr == TLPTX_OFS_STATUS;
  wire sel_ist = paddr == TLPTX_OFS_INT_STAT;
  wire sel_iclr = paddr == TLPTX_OFS_INT_CLR;
  wire sel_ien = paddr == TLPTX_OFS_INT_EN;
  wire mapped = sel_ctrl | sel_len | sel_seed | sel_abort | sel_go |
                sel_stat | sel_ist | sel_iclr | sel_ien;
  wire access = psel & penable & !pready;
  wire wr_en = psel & penable & pready & pwrite;

  logic [TLPTX_CTRL_W-1:0] ctrl;
  logic [TLPTX_LEN_W-1:0] len_dw;
  logic [31:0] seed;
  logic [TLPTX_BEAT_W-1:0] abort_beat;
  logic [TLPTX_INT_W-1:0] int_stat, int_en;
  logic req_q;

  tlptx_gen_t state;
  logic [TLPTX_LEN_W-1:0] rem, dwn;
  logic [TLPTX_BEAT_W-1:0] bidx;
  logic [DATA_W-1:0] tdata;
  logic [KB-1:0] tkeep;
  logic tvalid, tlast, gnt;
  logic [TLPTX_USER_W-1:0] tuser;

  wire [31:0] status = {16'h0000, 2'b00, lnk.free_buffer_count,
                        6'h00, lnk.cfg_req, state == TLPTX_SEND};
  wire [31:0] rd_mux =
    sel_ctrl ? 32'(ctrl) :
    sel_len ? 32'(len_dw) :
    sel_seed ? seed :
    sel_abort ? 32'(abort_beat) :
    sel_stat ? status :
    sel_ist ? 32'(int_stat) :
    sel_ien ? 32'(int_en) : 32'h0000_0000;

  // Handshake with the core
  wire hs = tvalid & lnk.tready;
  wire go = wr_en & sel_go & (state == TLPTX_IDLE) & (len_dw != '0);
  wire stream_on = ctrl[TLPTX_CTRL_STREAM];

  // Interrupt events
  wire ev_sent = hs & tlast;
  wire ev_drop = lnk.err_drop;
  wire ev_req = lnk.cfg_req & !req_q;
  wire [TLPTX_INT_W-1:0] events = {ev_req, ev_drop, ev_sent};
  wire [TLPTX_INT_W-1:0] clr = (wr_en & sel_iclr) ?
                               pwdata[TLPTX_INT_W-1:0] : '0;
  // A new event beats a clear in the same cycle
  wire [TLPTX_INT_W-1:0] next_int_stat = (int_stat & ~clr) | events;

  // Next beat position
  wire [TLPTX_LEN_W-1:0] next_rem = go ? len_dw : rem - DPB_L;
  wire [TLPTX_LEN_W-1:0] next_dwn = go ? '0 : dwn + DPB_L;
  wire [TLPTX_BEAT_W-1:0] next_bidx = go ? '0 : bidx + 8'h01;
  // Start beat can never be the discontinue point
  wire next_abort = ctrl[TLPTX_CTRL_ABORT] & (abort_beat != '0) &
                    (next_bidx == abort_beat);
  wire next_last = (next_rem <= DPB_L) | next_abort;
  wire load = go | (hs & !tlast);

  logic [DATA_W-1:0] next_tdata;
  logic [KB-1:0] next_tkeep;
  logic [TLPTX_USER_W-1:0] next_tuser;

  // Beat contents: incrementing dwords, keep as whole dwords
  always_comb begin
    next_tdata = '0;
    next_tkeep = '0;
    for (int i = 0; i < DPB; i++) begin
      next_tdata[32*i +: 32] = seed + 32'(next_dwn) + 32'(i);
      if (!next_last || next_abort || 32'(i) < 32'(next_rem)) begin
        next_tkeep[4*i +: 4] = 4'hf;
      end
    end
  end

  always_comb begin
    next_tuser = '0;
    next_tuser[TLPTX_U_ECRC] = ctrl[TLPTX_CTRL_ECRC] &
                               (next_bidx == '0);
    // Poisoning a cut-through packet is not allowed
    next_tuser[TLPTX_U_POISON] = ctrl[TLPTX_CTRL_POISON] & !stream_on;
    next_tuser[TLPTX_U_STREAM] = stream_on;
    next_tuser[TLPTX_U_DISCONT] = next_abort;
  end

  // Pulse mode grants once per rising request, else grant is held
  wire next_gnt = ctrl[TLPTX_CTRL_GNT_PULSE] ? ev_req : 1'b1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & !mapped;
      if (access) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= '0;
      len_dw <= '0;
      seed <= 32'h0000_0000;
      abort_beat <= '0;
      int_en <= '0;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl <= pwdata[TLPTX_CTRL_W-1:0];
      end
      if (sel_len) begin
        len_dw <= pwdata[TLPTX_LEN_W-1:0];
      end
      if (sel_seed) begin
        seed <= pwdata;
      end
      if (sel_abort) begin
        abort_beat <= pwdata[TLPTX_BEAT_W-1:0];
      end
      if (sel_ien) begin
        int_en <= pwdata[TLPTX_INT_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      int_stat <= '0;
      irq <= 1'b0;
      req_q <= 1'b0;
      gnt <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq <= |(next_int_stat & int_en);
      req_q <= lnk.cfg_req;
      gnt <= next_gnt;
    end
  end

  // Valid stays up until taken, so streamed packets never gap
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= TLPTX_IDLE;
      tvalid <= 1'b0;
      tlast <= 1'b0;
      tdata <= '0;
      tkeep <= '0;
      tuser <= '0;
      rem <= '0;
      dwn <= '0;
      bidx <= '0;
    end else begin
      case (state)
        TLPTX_IDLE: begin
          if (go) begin
            state <= TLPTX_SEND;
          end
        end
        TLPTX_SEND: begin
          if (hs && tlast) begin
            state <= TLPTX_IDLE;
          end
        end
        default: begin
          state <= TLPTX_IDLE;
        end
      endcase
      if (load) begin
        tvalid <= 1'b1;
        tlast <= next_last;
        tdata <= next_tdata;
        tkeep <= next_tkeep;
        tuser <= next_tuser;
        rem <= next_rem;
        dwn <= next_dwn;
        bidx <= next_bidx;
      end else if (hs) begin
        tvalid <= 1'b0;
        tlast <= 1'b0;
      end
    end
  end

  assign lnk.tdata = tdata;
  assign lnk.tkeep = tkeep;
  assign lnk.tvalid = tvalid;
  assign lnk.tlast = tlast;
  assign lnk.tuser = tuser;
  assign lnk.cfg_gnt = gnt;
endmodule

// [dv/tlptx_chk.sv]
`timescale 1ns/1ps
module tlptx_chk
  import tlptx_pkg::*;
#(
  parameter int DATA_W = TLPTX_DATA_W,
  parameter int NUM_BUFS = TLPTX_NUM_BUFS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Stream
  input wire logic [DATA_W-1:0] tdata,
  input wire logic [DATA_W/8-1:0] tkeep,
  input wire logic tvalid,
  input wire logic tready,
  input wire logic tlast,
  input wire logic [TLPTX_USER_W-1:0] tuser,
  // Status and grant
  input wire logic [TLPTX_CNT_W-1:0] free_buffer_count,
  input wire logic err_drop,
  input wire logic cfg_req,
  input wire logic cfg_gnt
);
  logic in_pkt;
  wire taken = tvalid && tready;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Start beat is the one after a last beat or after reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_pkt <= 1'b0;
    end else if (taken) begin
      in_pkt <= !tlast;
    end
  end
  a_hold_until_taken: assert property (tvalid && !tready |=>
    tvalid && $stable({tdata, tkeep, tlast, tuser}))
    else $error("beat changed before it was taken");
  a_keep_mid_full: assert property (tvalid && !tlast |-> &tkeep)
    else $error("partial keep on a non-final beat");
  a_keep_last_run: assert property (tvalid && tlast |->
    tkeep[3:0] == 4'hf && (tkeep & (tkeep + 1'b1)) == '0 &&
    $countones(tkeep) % 4 == 0) else $error("illegal final keep");
  a_dsc_with_last: assert property (tvalid && tuser[3] |-> tlast)
    else $error("discontinue without last");
  a_dsc_not_start: assert property (tvalid && !in_pkt |-> !tuser[3])
    else $error("discontinue on a start beat");
  a_stream_no_poison: assert property (tvalid && tuser[2] |-> !tuser[1])
    else $error("poison on a streamed packet");
  a_ecrc_first_only: assert property (tvalid && in_pkt |-> !tuser[0])
    else $error("digest request after the first beat");
  a_stream_no_gap: assert property (taken && !tlast && tuser[2] |=> tvalid)
    else $error("gap inside a streamed packet");
  a_free_in_range: assert property (free_buffer_count <= NUM_BUFS)
    else $error("free buffer count above buffer total");
  a_drop_one_cycle: assert property ($rose(err_drop) |=> !err_drop)
    else $error("drop flag longer than one cycle");
  a_grant_answers: assert property ($rose(cfg_req) |-> ##[0:1] cfg_gnt)
    else $error("no grant after request");
  c_stream_end: cover property (taken && tlast && tuser[2]);
  c_dsc_end: cover property (taken && tuser[3]);
  c_stall: cover property (tvalid && !tready);
  c_req: cover property ($rose(cfg_req));
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb import tlptx_pkg::*;;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, internal_post;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, last_rd;
  logic pready, pslverr, irq, internal_sent, link_sent, last_err;
  logic [76:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 33694;
  int drops = 0;
  int isent = 0;
  int lsent = 0;
  tlptx_if lnk ();
  tlptx_if bad ();
  tlptx_user_end i_tlptx_user_end (.clock(clock),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lnk(lnk.user));
  tlptx_core_end i_tlptx_core_end (
    .clock(clock), .arst_n(arst_n), .lnk(lnk.core),
    .internal_post(internal_post), .internal_sent(internal_sent),
    .link_sent(link_sent));
  // Second core end faces a rule-breaking driver
  tlptx_core_end i_tlptx_core_end_bad (
    .clock(clock), .arst_n(arst_n), .lnk(bad.core),
    .internal_post(1'b0), .internal_sent(), .link_sent());
  tlptx_chk i_tlptx_chk (.clock(clock),
    .arst_n(arst_n), .tdata(lnk.tdata), .tkeep(lnk.tkeep),
    .tvalid(lnk.tvalid), .tready(lnk.tready), .tlast(lnk.tlast),
    .tuser(lnk.tuser), .free_buffer_count(lnk.free_buffer_count),
    .err_drop(lnk.err_drop), .cfg_req(lnk.cfg_req), .cfg_gnt(lnk.cfg_gnt));

  always #5 clock = ~clock;

  task automatic chk(input string nm, input logic [76:0] ex,
                     input logic [76:0] got);
    checks_done++;
    if (got !== ex) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), ex, last_rd);
  endtask

  // Expected beats are noted before GO so the monitor never runs ahead
  task automatic send(input logic [4:0] c, input int len, input int k);
    logic [31:0] s;
    logic l;
    logic [7:0] kp;
    logic [3:0] u;
    int n;
    s = $random(seed);
    apb(1'b1, TLPTX_OFS_CTRL, {27'h0, c});
    apb(1'b1, TLPTX_OFS_LEN, len);
    apb(1'b1, TLPTX_OFS_SEED, s);
    apb(1'b1, TLPTX_OFS_ABORT, k);
    for (int b = 0; b < (len + 1) / 2; b++) begin
      l = (b == (len + 1) / 2 - 1);
      kp = (len - 2 * b >= 2) ? 8'hff : 8'h0f;
      u = {1'b0, c[0], c[1] & ~c[0], c[2] & (b == 0)};
      if (c[4] && b == k) begin
        l = 1'b1;
        kp = 8'hff;
        u[3] = 1'b1;
      end
      exp_q.push_back({l, u, kp, 32'(s + 2 * b + 1), 32'(s + 2 * b)});
      if (l) break;
    end
    apb(1'b1, TLPTX_OFS_GO, 32'h0);
    n = 0;
    do begin
      apb(1'b0, TLPTX_OFS_STATUS, 32'h0);
      n++;
    end while (last_rd[0] !== 1'b0 && n < 100);
  endtask

  task automatic bbeat(input logic [7:0] k, input logic l, input logic [3:0] u);
    bad.tvalid <= 1'b1;
    bad.tkeep <= k;
    bad.tlast <= l;
    bad.tuser <= u;
    bad.tdata <= {$random(seed), $random(seed)};
    do @(posedge clock); while (bad.tready !== 1'b1);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  always @(posedge clock) begin
    if (arst_n && lnk.tvalid === 1'b1 && lnk.tready === 1'b1) begin
      chk("beat", exp_q.size() ? exp_q.pop_front() : 'x, {lnk.tlast,
        lnk.tuser, lnk.tkeep, lnk.tdata});
    end
    if (bad.err_drop === 1'b1) drops++;
    if (internal_sent === 1'b1) isent++;
    if (link_sent === 1'b1) lsent++;
  end

  initial begin
    {psel, penable, pwrite, internal_post, paddr, pwdata} = '0;
    {bad.tvalid, bad.tlast, bad.tkeep, bad.tuser, bad.tdata} = '0;
    bad.cfg_gnt = 1'b1;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    rd(TLPTX_OFS_STATUS, 32'h0000_0800);
    rd(8'h24, 32'h0);
    chk("slverr", 1, last_err);
    // Broken traffic: short mid keep, stream gap, bad final keep
    bbeat(8'h0f, 1'b0, 4'h0);
    bbeat(8'hff, 1'b1, 4'h0);
    bbeat(8'hff, 1'b0, 4'h4);
    bad.tvalid <= 1'b0;
    @(posedge clock);
    bbeat(8'hff, 1'b1, 4'h4);
    bbeat(8'h07, 1'b1, 4'h0);
    bad.tvalid <= 1'b0;
    repeat (4) @(posedge clock);
    chk("drops", 3, drops);
    apb(1'b1, TLPTX_OFS_INT_EN, 32'h7);
    for (int m = 0; m < 8; m++) begin
      send(5'(m), m == 0 ? 1 : m == 7 ? 68 : 1 + {$random(seed)} % 68, 0);
      rd(TLPTX_OFS_INT_STAT, 32'h1);
      chk("irq", 1, irq);
      apb(1'b1, TLPTX_OFS_INT_CLR, 32'h7);
      repeat (2) @(posedge clock);
      chk("irq", 0, irq);
    end
    send(5'h10, 8, 2);
    apb(1'b0, TLPTX_OFS_INT_STAT, 32'h0);
    chk("drop flag", 0, last_rd[1]);
    apb(1'b1, TLPTX_OFS_INT_CLR, 32'h7);
    // Pulse grant first, then the held grant
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, TLPTX_OFS_CTRL, g == 0 ? 32'h8 : 32'h0);
      @(posedge clock);
      internal_post <= 1'b1;
      @(posedge clock);
      internal_post <= 1'b0;
      do @(posedge clock); while (lnk.cfg_req !== 1'b1);
      do @(posedge clock); while (lnk.cfg_req !== 1'b0);
      // Let the counting process see the sent pulse first
      @(posedge clock);
      chk("internal sent", g + 1, isent);
      rd(TLPTX_OFS_INT_STAT, 32'h4);
      chk("irq", 1, irq);
      apb(1'b1, TLPTX_OFS_INT_CLR, 32'h7);
    end
    // Stored packets drain at a fixed pace; every buffer must come back
    repeat (250) @(posedge clock);
    chk("link sent", 10, lsent);
    rd(TLPTX_OFS_STATUS, 32'h0000_0800);
    chk("beats left", 0, exp_q.size());
    tally_and_finish;
  end
endmodule
